// ### verilog/sfl_map.vh
/*
  Register offsets, field positions, reset values and sizes for the
  frame status FIFO and loop repeater channel block.
  Assumes a plain register port with 4-bit addresses and 8-bit data.
*/
`ifndef SFL_MAP_VH
`define SFL_MAP_VH

// ****************************************************************
// register offsets
// ****************************************************************
`define SFL_ADDR_EXT_STATUS      4'h0
`define SFL_ADDR_SPECIAL_RX      4'h1
`define SFL_ADDR_LIVE_2          4'h2
`define SFL_ADDR_LIVE_3          4'h3
`define SFL_ADDR_MIRROR_EXT      4'h4
`define SFL_ADDR_COUNT_LOW       4'h6
`define SFL_ADDR_COUNT_HIGH      4'h7
`define SFL_ADDR_INT_MODE        4'h8
`define SFL_ADDR_MISC_LINE       4'hA
`define SFL_ADDR_EXT_FEATURE     4'hF

// ****************************************************************
// field positions
// ****************************************************************
`define SFL_BIT_FIFO_EN          2
`define SFL_BIT_DATA_AVAIL       6
`define SFL_BIT_OVERFLOW         7
`define SFL_BIT_LOOP_MODE        1
`define SFL_BIT_GO_ACTIVE        4
`define SFL_BIT_ON_LOOP          1
`define SFL_BIT_LOOP_SENDING     4
`define SFL_BIT_BREAK_EOP        7
`define SFL_BIT_RXI_D3           3
`define SFL_BIT_RXI_D4           4

// ****************************************************************
// sizes and reset values
// ****************************************************************
`define SFL_FIFO_DEPTH           10
`define SFL_FIFO_WIDTH           19
`define SFL_COUNT_WIDTH          14
`define SFL_PTR_LAST             4'h9
`define SFL_RESET_BYTE           8'h00
`define SFL_END_OF_POLL          8'hFE
`define SFL_FLAG_PATTERN         8'h7E

`endif

// ### verilog/sfl_status_fifo.v
/*
  Ten-entry, 19-bit frame status FIFO with pop guard and sticky
  overflow. Assumes push and pop are one-cycle pulses on clk.
*/
`timescale 1ns/100ps
`include "sfl_map.vh"

module sfl_status_fifo (
  // clock and reset
  input  wire        clk,
  input  wire        reset,
  // control
  input  wire        clear,
  input  wire        push,
  input  wire [18:0] push_data,
  input  wire        pop,
  // state
  output wire [18:0] head_data,
  output wire        not_empty,
  output reg         overflow_reg
);

  // ****************************************************************
  // storage and pointers
  // ****************************************************************
  reg [18:0] mem_reg [0:`SFL_FIFO_DEPTH-1];
  reg [3:0]  wr_ptr_reg;
  reg [3:0]  rd_ptr_reg;
  reg [3:0]  count_reg;
  wire       full;
  wire       do_push;
  wire       do_pop;

  // wrap an index at the last slot
  function [3:0] bump;
    input [3:0] p;
    begin
      bump = (p == `SFL_PTR_LAST) ? 4'h0 : p + 4'h1;
    end
  endfunction

  assign full      = (count_reg == 4'hA);
  assign not_empty = (count_reg != 4'h0);
  assign head_data = mem_reg[rd_ptr_reg];
  assign do_push   = push && !full;
  assign do_pop    = pop && not_empty;

  // pointers clear while disabled; overflow also clears while disabled
  always @(posedge clk) begin
    if (reset || clear) begin
      wr_ptr_reg   <= 4'h0;
      rd_ptr_reg   <= 4'h0;
      count_reg    <= 4'h0;
      overflow_reg <= 1'b0;
    end else begin
      if (push && full)
        overflow_reg <= 1'b1;
      if (do_push)
        wr_ptr_reg <= bump(wr_ptr_reg);
      if (do_pop)
        rd_ptr_reg <= bump(rd_ptr_reg);
      if (do_push && !do_pop)
        count_reg <= count_reg + 4'h1;
      else if (do_pop && !do_push)
        count_reg <= count_reg - 4'h1;
    end
  end

  // entry write; no reset needed for data
  always @(posedge clk) begin
    if (do_push)
      mem_reg[wr_ptr_reg] <= push_data;
  end

endmodule // sfl_status_fifo

// ### verilog/sfl_channel.v
/*
  Channel logic for the frame status FIFO and the loop repeater of a
  secondary station. Assumes the framer supplies end-of-frame pulses,
  byte counts and live status, and that line data is sampled on clk
  once per bit time via rx_bit_tick.
*/
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/100ps
`include "sfl_map.vh"

module sfl_channel (
  // clock and reset
  input  wire        clk,
  input  wire        reset,
  // register port
  input  wire [3:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_write,
  input  wire        reg_read,
  output reg  [7:0]  reg_rdata,
  // framer side
  input  wire        sdlc_mode,
  input  wire        frame_end,
  input  wire [13:0] frame_count,
  input  wire [7:0]  live_status,
  input  wire [7:0]  live_ext_status,
  input  wire [7:0]  live_reg2,
  input  wire [7:0]  live_reg3,
  input  wire        rx_top_valid,
  input  wire        rx_top_eof,
  input  wire        rx_top_error,
  input  wire        rx_char_read,
  input  wire        error_reset,
  input  wire        tx_data_valid,
  input  wire        tx_data_bit,
  input  wire        tx_frame_done,
  // serial loop
  input  wire        rx_bit_tick,
  input  wire        rxd_pin,
  output wire        txd,
  // events
  output reg         rx_data_int_reg,
  output reg         special_rx_int_reg,
  output reg         ext_status_int_reg,
  output wire        rx_fifo_locked
);

  // ****************************************************************
  // loop states
  // ****************************************************************
  localparam [2:0] ST_OFF      = 3'h0; // transparent repeat
  localparam [2:0] ST_HUNT     = 3'h1; // on loop, awaiting flag
  localparam [2:0] ST_ARMED    = 3'h2; // flag seen, awaiting poll
  localparam [2:0] ST_SEND     = 3'h3; // sending own frame
  localparam [2:0] ST_CLOSE    = 3'h4; // closing flag out
  localparam [2:0] ST_LEAVE    = 3'h5; // off command, delay kept

  // ****************************************************************
  // control registers
  // ****************************************************************
  reg  [7:0] ext_feature_reg;
  reg  [7:0] misc_control_reg;
  reg  [7:0] int_mode_reg;
  reg        ext_int_en_reg;
  wire       fifo_en;
  wire       fifo_clear;
  wire       anti_lock;

  assign fifo_en    = ext_feature_reg[`SFL_BIT_FIFO_EN] && sdlc_mode;
  assign fifo_clear = !fifo_en;
  assign anti_lock  = fifo_en && int_mode_reg[`SFL_BIT_RXI_D4]
                      && int_mode_reg[`SFL_BIT_RXI_D3];

  // software-written control; enable starts cleared
  always @(posedge clk) begin
    if (reset) begin
      ext_feature_reg  <= `SFL_RESET_BYTE;
      misc_control_reg <= `SFL_RESET_BYTE;
      int_mode_reg     <= `SFL_RESET_BYTE;
      ext_int_en_reg   <= 1'b0;
    end else if (reg_write) begin
      case (reg_addr)
        `SFL_ADDR_EXT_FEATURE: ext_feature_reg  <= reg_wdata;
        `SFL_ADDR_MISC_LINE:   misc_control_reg <= reg_wdata;
        `SFL_ADDR_INT_MODE: begin
          int_mode_reg   <= reg_wdata;
          ext_int_en_reg <= reg_wdata[0];
        end
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // frame status FIFO
  // ****************************************************************
  wire [18:0] head_data;
  wire [18:0] push_data;
  wire        fifo_avail;
  wire        overflow;
  reg         avail_latch_reg;
  wire        status_pop;

  // keep only residue(3:1), overrun(5), CRC(6) beside the count
  assign push_data = {frame_count, live_status[6:5],
                      live_status[3:1]};
  assign status_pop = reg_read && (reg_addr == `SFL_ADDR_SPECIAL_RX)
                      && fifo_en && avail_latch_reg;

  sfl_status_fifo u_fifo (
    .clk          (clk),
    .reset        (reset),
    .clear        (fifo_clear),
    .push         (frame_end && fifo_en),
    .push_data    (push_data),
    .pop          (status_pop),
    .head_data    (head_data),
    .not_empty    (fifo_avail),
    .overflow_reg (overflow)
  );

  // high count read latches availability; a status read then pops
  // once, so a second status read cannot drain another entry
  always @(posedge clk) begin
    if (reset || fifo_clear)
      avail_latch_reg <= 1'b0;
    else if (reg_read && reg_addr == `SFL_ADDR_COUNT_HIGH)
      avail_latch_reg <= fifo_avail;
    else if (status_pop)
      avail_latch_reg <= 1'b0;
  end

  // ****************************************************************
  // loop repeater
  // ****************************************************************
  reg        rxd_meta_reg;
  reg        rxd_sync_reg;
  reg        delay_bit_reg;
  reg  [7:0] shift_reg;
  reg  [2:0] loop_state_reg;
  reg  [2:0] loop_state_next;
  reg        break_eop_reg;
  reg        flag_out_reg;
  reg  [2:0] flag_cnt_reg;
  wire       loop_mode;
  wire       go_active;
  wire [7:0] shift_now;
  wire       poll_seen;
  wire       flag_seen;
  wire       delay_on;
  wire       sending;
  wire [7:0] flag_bits;

  assign loop_mode = misc_control_reg[`SFL_BIT_LOOP_MODE];
  assign flag_bits = `SFL_FLAG_PATTERN;
  assign go_active = misc_control_reg[`SFL_BIT_GO_ACTIVE];
  assign shift_now = {shift_reg[6:0], rxd_sync_reg};
  assign poll_seen = rx_bit_tick && (shift_now == `SFL_END_OF_POLL);
  assign flag_seen = rx_bit_tick && (shift_now == `SFL_FLAG_PATTERN);
  assign delay_on  = (loop_state_reg != ST_OFF);
  assign sending   = (loop_state_reg == ST_SEND)
                     || (loop_state_reg == ST_CLOSE);

  // pin input passes two flops before the pattern logic
  always @(posedge clk) begin
    if (reset) begin
      rxd_meta_reg <= 1'b1;
      rxd_sync_reg <= 1'b1;
    end else begin
      rxd_meta_reg <= rxd_pin;
      rxd_sync_reg <= rxd_meta_reg;
    end
  end

  // pattern shifter and one-bit delay stage
  always @(posedge clk) begin
    if (reset) begin
      shift_reg     <= 8'hFF;
      delay_bit_reg <= 1'b1;
    end else if (rx_bit_tick) begin
      shift_reg     <= shift_now;
      delay_bit_reg <= rxd_sync_reg;
    end
  end

  // loop state sequencing
  always @* begin
    loop_state_next = loop_state_reg;
    case (loop_state_reg)
      ST_OFF:
        if (loop_mode && poll_seen)
          loop_state_next = ST_HUNT;
      ST_HUNT:
        if (!loop_mode)
          loop_state_next = ST_LEAVE;
        else if (flag_seen)
          loop_state_next = ST_ARMED;
      ST_ARMED:
        if (!loop_mode)
          loop_state_next = ST_LEAVE;
        else if (poll_seen && go_active)
          loop_state_next = ST_SEND;
        else if (poll_seen)
          loop_state_next = ST_HUNT;
      ST_SEND:
        if (tx_frame_done)
          loop_state_next = ST_CLOSE;
      ST_CLOSE:
        if (rx_bit_tick && flag_cnt_reg == 3'h7)
          loop_state_next = loop_mode ? ST_HUNT : ST_LEAVE;
      ST_LEAVE:
        if (poll_seen)
          loop_state_next = ST_OFF;
      default:
        loop_state_next = ST_OFF;
    endcase
  end

  // state register, break/end-of-poll event and closing flag count
  always @(posedge clk) begin
    if (reset) begin
      loop_state_reg <= ST_OFF;
      break_eop_reg  <= 1'b0;
      flag_cnt_reg   <= 3'h0;
      flag_out_reg   <= 1'b0;
    end else begin
      loop_state_reg <= loop_state_next;
      if (loop_mode && poll_seen)
        break_eop_reg <= 1'b1;
      else if (reg_read && reg_addr == `SFL_ADDR_EXT_STATUS)
        break_eop_reg <= 1'b0;
      if (loop_state_reg == ST_CLOSE && rx_bit_tick)
        flag_cnt_reg <= flag_cnt_reg + 3'h1;
      else if (loop_state_reg != ST_CLOSE)
        flag_cnt_reg <= 3'h0;
      // final one of the poll leaves as zero, making a flag
      flag_out_reg <= (loop_state_next == ST_SEND)
                      && (loop_state_reg == ST_ARMED);
    end
  end

  // transparent path uses gates only; on loop, repeat one bit late
  assign txd = !delay_on ? rxd_pin :
               flag_out_reg ? 1'b0 :
               (loop_state_reg == ST_SEND && tx_data_valid) ?
                 tx_data_bit :
               (loop_state_reg == ST_CLOSE) ?
                 flag_bits[~flag_cnt_reg] :
               delay_bit_reg;

  // ****************************************************************
  // receive interrupt and lock
  // ****************************************************************
  reg lock_reg;

  assign rx_fifo_locked = lock_reg;

  // anti-lock gives a data vector for frame ends; errors still lock
  always @(posedge clk) begin
    if (reset) begin
      lock_reg           <= 1'b0;
      rx_data_int_reg    <= 1'b0;
      special_rx_int_reg <= 1'b0;
      ext_status_int_reg <= 1'b0;
    end else begin
      rx_data_int_reg    <= anti_lock && rx_top_valid
                            && rx_top_eof && !lock_reg;
      special_rx_int_reg <= rx_char_read && rx_top_error;
      ext_status_int_reg <= loop_mode && poll_seen
                            && ext_int_en_reg;
      if (rx_char_read && (rx_top_error
          || (rx_top_eof && !anti_lock)))
        lock_reg <= 1'b1;
      else if (error_reset)
        lock_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // read data
  // ****************************************************************
  reg [7:0] rd_mux;

  // status read path; empty or disabled goes to live status
  always @* begin
    case (reg_addr)
      `SFL_ADDR_EXT_STATUS, `SFL_ADDR_MIRROR_EXT:
        rd_mux = {break_eop_reg, live_ext_status[6:0]};
      `SFL_ADDR_SPECIAL_RX, 4'h5:
        rd_mux = (fifo_en && fifo_avail) ?
                 {live_status[7], head_data[4:3], live_status[4],
                  head_data[2:0], live_status[0]}
                 : live_status;
      `SFL_ADDR_LIVE_2:
        rd_mux = live_reg2;
      `SFL_ADDR_LIVE_3:
        rd_mux = live_reg3;
      `SFL_ADDR_COUNT_LOW:
        rd_mux = fifo_en ? head_data[12:5] : live_reg2;
      `SFL_ADDR_COUNT_HIGH:
        rd_mux = fifo_en ? {overflow, fifo_avail,
                            head_data[18:13]} : live_reg3;
      `SFL_ADDR_MISC_LINE:
        rd_mux = {3'h0, sending, 2'h0, delay_on, 1'b0};
      `SFL_ADDR_EXT_FEATURE:
        rd_mux = {5'h00, fifo_en, 2'h0};
      default:
        rd_mux = 8'h00;
    endcase
  end

  // read data stands in the cycle after the strobe only
  always @(posedge clk) begin
    if (reset)
      reg_rdata <= 8'h00;
    else if (reg_read)
      reg_rdata <= rd_mux;
    else
      reg_rdata <= 8'h00;
  end

endmodule // sfl_channel

// ### bench/sfl_channel_properties.sv
/*
  Port checker for sfl_channel, bound to every instance.
  Assumes synchronous reset before the first register access.
*/
`timescale 1ns/100ps
module sfl_channel_checks (
  // clock and reset
  input wire       clk,
  input wire       reset,
  // register port
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_write,
  input wire       reg_read,
  input wire [7:0] reg_rdata,
  // framer side
  input wire       sdlc_mode,
  input wire [7:0] live_status,
  input wire [7:0] live_reg2,
  input wire [7:0] live_reg3,
  input wire       rx_top_valid,
  input wire       rx_top_eof,
  input wire       rx_top_error,
  input wire       rx_char_read,
  input wire       error_reset,
  // loop and events
  input wire       rxd_pin,
  input wire       txd,
  input wire       rx_data_int_reg,
  input wire       special_rx_int_reg,
  input wire       rx_fifo_locked
);
  // ****************************************************
  // control shadow
  // ****************************************************
  reg       en_q;
  reg [1:0] mode_q;
  reg       loop_q;
  wire      fifo_on = en_q && sdlc_mode;
  wire      anti    = fifo_on && mode_q == 2'h3;
  // rebuilt from bus writes, so no view inside the block is needed
  always @(posedge clk) begin
    if (reset) begin
      en_q   <= 1'b0;
      mode_q <= 2'h0;
      loop_q <= 1'b0;
    end else if (reg_write) begin
      if (reg_addr == 4'hF)
        en_q <= reg_wdata[2];
      if (reg_addr == 4'h8)
        mode_q <= reg_wdata[4:3];
      if (reg_addr == 4'hA && reg_wdata[1])
        loop_q <= 1'b1;
    end
  end
  // ****************************************************
  // properties
  // ****************************************************
  property p_readback;
    @(posedge clk) disable iff (reset)
    reg_read && reg_addr == 4'hF && sdlc_mode |=>
      reg_rdata[2] == $past(en_q);
  endproperty
  a_readback: assert property (p_readback)
    else $error("readback enable bit wrong");
  property p_mirror;
    @(posedge clk) disable iff (reset)
    reg_read && reg_addr[3:1] == 3'h3 && !fifo_on |=> reg_rdata ==
      ($past(reg_addr) == 4'h7 ? $past(live_reg3) : $past(live_reg2));
  endproperty
  a_mirror: assert property (p_mirror)
    else $error("count address not mirrored");
  property p_bypass;
    @(posedge clk) disable iff (reset)
    reg_read && reg_addr == 4'h1 && !fifo_on |=>
      reg_rdata == $past(live_status);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("status not live while fifo off");
  property p_repeat;
    @(posedge clk) disable iff (reset)
    !loop_q |-> txd == rxd_pin;
  endproperty
  a_repeat: assert property (p_repeat)
    else $error("line not repeated");
  property p_special;
    @(posedge clk) disable iff (reset)
    rx_char_read && rx_top_error && !rx_fifo_locked |->
      ##[1:2] special_rx_int_reg ##[0:1] rx_fifo_locked;
  endproperty
  a_special: assert property (p_special)
    else $error("errored read did not lock");
  property p_lock_hold;
    @(posedge clk) disable iff (reset)
    rx_fifo_locked && !error_reset |=> rx_fifo_locked;
  endproperty
  a_lock_hold: assert property (p_lock_hold)
    else $error("lock dropped without error reset");
  property p_eof_int;
    @(posedge clk) disable iff (reset)
    anti && rx_top_valid && rx_top_eof && !rx_top_error &&
      !rx_fifo_locked |-> ##[1:2] rx_data_int_reg;
  endproperty
  a_eof_int: assert property (p_eof_int)
    else $error("no data vector for frame end");
  property p_no_lock;
    @(posedge clk) disable iff (reset)
    anti && rx_char_read && rx_top_eof && !rx_top_error &&
      !rx_fifo_locked |=> !rx_fifo_locked [*2];
  endproperty
  a_no_lock: assert property (p_no_lock)
    else $error("frame end locked the fifo");
endmodule // sfl_channel_checks

bind sfl_channel sfl_channel_checks sfl_channel_checks_i (
  .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .sdlc_mode(sdlc_mode), .live_status(live_status),
  .live_reg2(live_reg2), .live_reg3(live_reg3),
  .rx_top_valid(rx_top_valid), .rx_top_eof(rx_top_eof),
  .rx_top_error(rx_top_error), .rx_char_read(rx_char_read),
  .error_reset(error_reset), .rxd_pin(rxd_pin), .txd(txd),
  .rx_data_int_reg(rx_data_int_reg),
  .special_rx_int_reg(special_rx_int_reg),
  .rx_fifo_locked(rx_fifo_locked)
);

// ### bench/sfl_loop_primary.sv
/*
  Loop primary model: sends bit patterns round the loop.
  Assumes its tasks are entered just after a rising edge.
*/
`timescale 1ns/100ps
module sfl_loop_primary #(
  parameter BIT_CYCLES = 8
) (
  // clock
  input  wire clk,
  // serial loop
  output reg  rx_bit_tick,
  output reg  rxd_pin
);
  // ****************************************************
  // line driver
  // ****************************************************
  // the loop marks idle, so the line rests high
  initial begin
    rx_bit_tick = 1'b0;
    rxd_pin     = 1'b1;
  end
  // tick in mid-bit so the synchronised level has settled
  task send_bit(input b);
    integer n;
    begin
      rxd_pin <= b;
      for (n = 0; n < BIT_CYCLES; n = n + 1) begin
        @(posedge clk);
        rx_bit_tick <= (n == BIT_CYCLES / 2);
      end
    end
  endtask
  // leftmost pattern bit goes on the line first
  task send_byte(input [7:0] p);
    integer k;
    begin
      for (k = 7; k >= 0; k = k - 1)
        send_bit(p[k]);
    end
  endtask
endmodule // sfl_loop_primary

// ### bench/test_sdlc_status_fifo_loop.sv
/*
  Self-checking bench for sfl_channel with a loop primary model.
  Assumes the checker file is compiled in for its bind.
*/
`timescale 1ns/100ps
`define CHK(nm, e, g) begin \
  n_tests = n_tests + 1; \
  if ((g) !== (e)) begin \
    fail_count = fail_count + 1; \
    $display("mismatch %s exp %h got %h", nm, e, g); \
  end \
end
module test_sdlc_status_fifo_loop;
  // ****************************************************
  // signals and instances
  // ****************************************************
  reg         clk = 1'b0, reset = 1'b1, sdlc_mode = 1'b1;
  reg  [3:0]  reg_addr = 4'h0;
  reg  [7:0]  reg_wdata = 8'h00, live_status = 8'h00;
  reg  [7:0]  live_ext_status = 8'h24, live_reg2 = 8'h5A;
  reg  [7:0]  live_reg3 = 8'hC3, d;
  reg  [13:0] frame_count = 14'h0000;
  reg         reg_write = 1'b0, reg_read = 1'b0, frame_end = 1'b0;
  reg         rx_top_valid = 1'b0, rx_top_eof = 1'b0;
  reg         rx_top_error = 1'b0, rx_char_read = 1'b0;
  reg         error_reset = 1'b0, tx_data_valid = 1'b0;
  reg         tx_data_bit = 1'b0, tx_frame_done = 1'b0;
  reg  [2:0]  seen = 3'h0;
  reg         seen_clr = 1'b0;
  wire [7:0]  reg_rdata;
  wire        rx_bit_tick, rxd_pin, txd, rx_data_int_reg;
  wire        special_rx_int_reg, ext_status_int_reg, rx_fifo_locked;
  integer     fail_count = 0, n_tests = 0, i;
  sfl_channel sfl_channel_i (
    .clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .sdlc_mode(sdlc_mode),
    .frame_end(frame_end), .frame_count(frame_count),
    .live_status(live_status), .live_ext_status(live_ext_status),
    .live_reg2(live_reg2), .live_reg3(live_reg3),
    .rx_top_valid(rx_top_valid), .rx_top_eof(rx_top_eof),
    .rx_top_error(rx_top_error), .rx_char_read(rx_char_read),
    .error_reset(error_reset), .tx_data_valid(tx_data_valid),
    .tx_data_bit(tx_data_bit), .tx_frame_done(tx_frame_done),
    .rx_bit_tick(rx_bit_tick), .rxd_pin(rxd_pin), .txd(txd),
    .rx_data_int_reg(rx_data_int_reg),
    .special_rx_int_reg(special_rx_int_reg),
    .ext_status_int_reg(ext_status_int_reg),
    .rx_fifo_locked(rx_fifo_locked));
  sfl_loop_primary #(.BIT_CYCLES(8)) sfl_loop_primary_i (
    .clk(clk), .rx_bit_tick(rx_bit_tick), .rxd_pin(rxd_pin));
  always #5 clk = ~clk;
  // poll and special event outputs are one-cycle pulses and the data event
  // follows its inputs, so keep them sticky; one driver only, so scenarios clear them through seen_clr
  always @(posedge clk)
    if (seen_clr)
      seen <= 3'h0;
    else
      seen <= seen | {ext_status_int_reg, special_rx_int_reg,
                      rx_data_int_reg};
  // ****************************************************
  // bus and strobe tasks
  // ****************************************************
  task wr(input [3:0] a, input [7:0] v);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
    end
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input [3:0] a);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      #1;
      d = reg_rdata;
    end
  endtask
  task clear_seen;
    begin
      seen_clr <= 1'b1;
      @(posedge clk);
      seen_clr <= 1'b0;
    end
  endtask
  task push(input [13:0] c, input [7:0] s);
    begin
      @(posedge clk);
      frame_count <= c;
      live_status <= s;
      frame_end <= 1'b1;
      @(posedge clk);
      frame_end <= 1'b0;
    end
  endtask
  task strobe(input sel);
    begin
      @(posedge clk);
      error_reset <= sel;
      rx_char_read <= !sel;
      @(posedge clk);
      error_reset <= 1'b0;
      rx_char_read <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
    end
  endtask
  // ****************************************************
  // scenarios
  // ****************************************************
  task t_off;
    begin
      live_reg2 <= 8'hA5;
      live_reg3 <= 8'h3C;
      live_ext_status <= 8'h51;
      rd(4'hF);
      `CHK("enable", 1'b0, d[2])
      rd(4'h4);
      `CHK("mirror", 8'h51, d)
      rd(4'h6);
      `CHK("cnt_lo", 8'hA5, d)
      rd(4'h7);
      `CHK("cnt_hi", 8'h3C, d)
      wr(4'hF, 8'h04);
      sdlc_mode <= 1'b0;
      push(14'h0011, 8'hFF);
      live_status <= 8'h96;
      rd(4'h1);
      `CHK("status", 8'h96, d)
      sdlc_mode <= 1'b1;
      rd(4'h7);
      `CHK("avail", 1'b0, d[6])
      $display("t_off done");
    end
  endtask
  // status bits 6,5,3:1 come from the entry, 7,4,0 stay live
  task t_fifo;
    begin
      rd(4'hF);
      `CHK("enable", 1'b1, d[2])
      push(14'h2ABC, 8'hFF);
      push(14'h0123, 8'hCB);
      live_status <= 8'h00;
      rd(4'h7);
      `CHK("cnt_hi", 8'h6A, d)
      rd(4'h6);
      `CHK("cnt_lo", 8'hBC, d)
      rd(4'h1);
      `CHK("status", 8'h6E, d)
      rd(4'h1);
      rd(4'h7);
      `CHK("cnt_hi", 8'h41, d)
      rd(4'h1);
      `CHK("status", 8'h4A, d)
      live_status <= 8'h91;
      rd(4'h7);
      `CHK("avail", 1'b0, d[6])
      rd(4'h1);
      `CHK("status", 8'h91, d)
      push(14'h0007, 8'h02);
      live_status <= 8'h91;
      rd(4'h7);
      `CHK("cnt_hi", 8'h40, d)
      rd(4'h1);
      `CHK("status", 8'h93, d)
      $display("t_fifo done");
    end
  endtask
  task t_ovf;
    begin
      for (i = 0; i < 10; i = i + 1)
        push(i[13:0], 8'h00);
      rd(4'h7);
      `CHK("cnt_hi", 8'h40, d)
      push(14'h3FFF, 8'h00);
      rd(4'h1);
      rd(4'h7);
      `CHK("ovf", 2'h3, d[7:6])
      wr(4'hF, 8'h00);
      wr(4'hF, 8'h04);
      rd(4'h7);
      `CHK("ovf", 2'h0, d[7:6])
      $display("t_ovf done");
    end
  endtask
  task t_int;
    begin
      wr(4'h8, 8'h18);
      clear_seen;
      rx_top_valid <= 1'b1;
      rx_top_eof <= 1'b1;
      strobe(1'b0);
      `CHK("data_int", 1'b1, seen[0])
      `CHK("lock", 1'b0, rx_fifo_locked)
      rx_top_eof <= 1'b0;
      rx_top_error <= 1'b1;
      strobe(1'b0);
      `CHK("lock", 1'b1, rx_fifo_locked)
      `CHK("special", 1'b1, seen[1])
      strobe(1'b1);
      `CHK("lock", 1'b0, rx_fifo_locked)
      rx_top_valid <= 1'b0;
      rx_top_error <= 1'b0;
      $display("t_int done");
    end
  endtask
  task t_loop;
    begin
      wr(4'h8, 8'h01);
      wr(4'hA, 8'h02);
      clear_seen;
      // sample the repeat of the zero before its tick completes a poll
      fork
        sfl_loop_primary_i.send_bit(1'b0);
        begin
          repeat (3) @(posedge clk);
          #1;
          `CHK("txd", 1'b0, txd)
        end
      join
      sfl_loop_primary_i.send_byte(8'hFF);
      `CHK("poll_int", 1'b1, seen[2])
      rd(4'hA);
      `CHK("on_loop", 1'b1, d[1])
      rd(4'h0);
      `CHK("poll_bit", 1'b1, d[7])
      wr(4'hA, 8'h12);
      sfl_loop_primary_i.send_byte(8'hFE);
      rd(4'hA);
      `CHK("sending", 1'b0, d[4])
      sfl_loop_primary_i.send_byte(8'h7E);
      sfl_loop_primary_i.send_byte(8'hFE);
      tx_data_valid <= 1'b1;
      tx_data_bit <= 1'b1;
      for (i = 0; i < 3; i = i + 1)
        sfl_loop_primary_i.send_byte(8'h00);
      rd(4'hA);
      `CHK("sending", 1'b1, d[4])
      `CHK("tx_data", 1'b1, txd)
      tx_frame_done <= 1'b1;
      @(posedge clk);
      tx_frame_done <= 1'b0;
      tx_data_valid <= 1'b0;
      for (i = 0; i < 3; i = i + 1)
        sfl_loop_primary_i.send_byte(8'hFF);
      rd(4'hA);
      `CHK("sending", 1'b0, d[4])
      wr(4'hA, 8'h00);
      rd(4'hA);
      `CHK("on_loop", 1'b1, d[1])
      sfl_loop_primary_i.send_byte(8'hFE);
      rd(4'hA);
      `CHK("on_loop", 1'b0, d[1])
      $display("t_loop done");
    end
  endtask
  // ****************************************************
  // sequence and verdict
  // ****************************************************
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    t_off;
    t_fifo;
    t_ovf;
    t_int;
    t_loop;
    report_and_stop;
  end
  // the scenarios need under a thousand cycles; this allows far more
  initial begin
    #500000;
    fail_count = fail_count + 1;
    report_and_stop;
  end
endmodule // test_sdlc_status_fifo_loop
